// ---- hw/cmd_access.sv ----
/*
 * Serial command interpreter with station address, access levels and
 * rate control. Assumes a UART outside that delivers received bytes and
 * sends bytes at the rate given by baud_div_out, and a non-volatile
 * store that returns the saved rate and address after reset.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Carriage return clears the receive buffer
// - Every accepted command gets a reply
// - Reply is exclamation, address, command, then value
// - Telegram commands reply with measurement data
// - Failed command replies with error telegram
// - Error 8 access, 16 range, 32 conflict
// - Three ordered levels, enquiry is default
// - Key 0 enquiry, 1 user, secret config
// - Key change replies level text then echo
// - Restart always begins at enquiry level
// - Rates span 1200 to 921600 baud
// - Normal command reaches only 115200 baud
// - Normal rate change acts immediately
// - Extended rate switches now, not stored
// - Repeated extended command stores the rate
// - Address 00 to 99, sent first always
// - New address confirmed and kept permanently
// - Optional start-up address from three pins
// - Telegram: address, command, optional value, CR
// - Defaults address 0, 9600, full duplex
module cmd_access
  import cmd_access_pkg::*;
#(
  parameter logic [16:0] CFG_KEY = 17'h03039  // Arbitrary value
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_valid_in,
  output logic             rx_ready_out,
  output logic [7:0]       tx_data_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic             tx_drive_out,
  input  wire logic [19:0] meas_bcd_in,
  input  wire logic [2:0]  ext_addr_pins_in,
  input  wire logic        nv_valid_in,
  input  wire logic        nv_ext_addr_in,
  input  wire logic [6:0]  nv_rate_in,
  input  wire logic [6:0]  nv_addr_in,
  output logic [6:0]       nv_rate_out,
  output logic [6:0]       nv_addr_out,
  output logic             nv_write_out,
  output logic [6:0]       rate_code_out,
  output logic [13:0]      baud_div_out,
  output logic [1:0]       access_level_out,
  output logic             cyclic_out,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_we_in,
  input  wire logic        reg_re_in,
  output logic [31:0]      reg_rdata_out
);

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic is_digit(input logic [7:0] c);
    return (c >= CH_ZERO) && (c <= CH_NINE);
  endfunction : is_digit

  function automatic logic [7:0] dec_char(input logic [16:0] v,
                                          input int unsigned p);
    logic [16:0] q;
    q = v;
    for (int k = 0; k < 4; k++) begin
      if (k < p) begin
        q = q / 17'd10;
      end
    end
    return CH_ZERO + 8'(q % 17'd10);
  endfunction : dec_char

  function automatic int unsigned rate_baud(input logic [6:0] code);
    case (code)
      7'h02:   return 1200;
      7'h03:   return 2400;
      7'h04:   return 4800;
      7'h06:   return 19200;
      7'h07:   return 38400;
      7'h08:   return 57600;
      7'h09:   return 115200;
      7'h65:   return 230400;
      7'h66:   return 460800;
      7'h67:   return 921600;
      default: return 9600;
    endcase
  endfunction : rate_baud

  // Text is right-justified; leading zero bytes are skipped
  function automatic logic [7:0] msg_char(input msg_e m,
                                          input logic [4:0] i);
    logic [127:0] s;
    case (m)
      MSG_WP:    s = "WRITE PROTECTED";
      MSG_USER:  s = "USER ACCESS";
      MSG_CFG:   s = "CONFIG ACCESS";
      MSG_SAVED: s = "BAUD RATE SAVED";
      default:   s = '0;
    endcase
    return s[8'(7'd15 - 7'(i)) * 8 +: 8];
  endfunction : msg_char

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic [2:0] pins_meta_ff;
  logic [2:0] pins_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pins_meta_ff <= 3'h0;
      pins_ff      <= 3'h0;
    end else begin
      pins_meta_ff <= ext_addr_pins_in;
      pins_ff      <= pins_meta_ff;
    end
  end

  // ****************************************
  // Interpreter state
  // ****************************************
  state_e     st_ff,      nxt_st;
  rxbuf_t     buf_ff,     nxt_buf;
  logic [3:0] cnt_ff,     nxt_cnt;
  level_e     lvl_ff,     nxt_lvl;
  logic [6:0] addr_ff,    nxt_addr;
  logic [6:0] rate_ff,    nxt_rate;
  logic [6:0] stored_ff,  nxt_stored;
  logic       pending_ff, nxt_pending;
  logic       cyclic_ff,  nxt_cyclic;
  logic       extad_ff,   nxt_extad;
  msg_e       msg_ff,     nxt_msg;
  logic [4:0] idx_ff,     nxt_idx;
  body_t      body_ff,    nxt_body;
  logic [4:0] bstart_ff,  nxt_bstart;
  logic [7:0] txd_ff,     nxt_txd;
  logic       txv_ff,     nxt_txv;
  logic       nvw_ff,     nxt_nvw;
  logic       drive_ff,   nxt_drive;
  logic       half_ff;

  always_comb begin
    logic        ok;
    logic        has_val;
    logic [19:0] v;
    logic [15:0] cmd;
    logic [16:0] echo;
    logic [16:0] err;
    logic [6:0]  eaddr;
    logic        data;
    logic [7:0]  c;
    ok          = 1'b0;
    has_val     = 1'b0;
    v           = 20'h0;
    cmd         = 16'h0;
    echo        = 17'h0;
    err         = 17'h0;
    eaddr       = addr_ff;
    data        = 1'b0;
    c           = 8'h0;
    nxt_st      = st_ff;
    nxt_buf     = buf_ff;
    nxt_cnt     = cnt_ff;
    nxt_lvl     = lvl_ff;
    nxt_addr    = addr_ff;
    nxt_rate    = rate_ff;
    nxt_stored  = stored_ff;
    nxt_pending = pending_ff;
    nxt_cyclic  = cyclic_ff;
    nxt_extad   = extad_ff;
    nxt_msg     = msg_ff;
    nxt_idx     = idx_ff;
    nxt_body    = body_ff;
    nxt_bstart  = bstart_ff;
    nxt_txd     = txd_ff;
    nxt_txv     = txv_ff && !tx_ready_in;
    nxt_nvw     = 1'b0;
    nxt_drive   = !half_ff || (st_ff == ST_MSG) || (st_ff == ST_ECHO) || txv_ff;
    case (st_ff)
      // Waits for the pin synchroniser to fill
      ST_LOAD: begin
        nxt_idx = idx_ff + 5'd1;
        if (idx_ff == 5'(LOAD_WAIT)) begin
          nxt_st     = ST_IDLE;
          nxt_idx    = 5'd0;
          nxt_rate   = nv_valid_in ? nv_rate_in : RATE_DEFAULT;
          nxt_stored = nxt_rate;
          nxt_addr   = nv_valid_in ? nv_addr_in : ADDR_DEFAULT;
          nxt_extad  = nv_valid_in && nv_ext_addr_in;
          if (nxt_extad) begin
            nxt_addr = {4'h0, pins_ff};
          end
        end
      end
      ST_IDLE: begin
        if (rx_valid_in) begin
          if (rx_data_in == CH_CR) begin
            nxt_st = ST_EXEC;
          end else if (cnt_ff < 4'(BUF_LEN)) begin
            nxt_buf[cnt_ff] = rx_data_in;
            nxt_cnt         = cnt_ff + 4'd1;
          end else begin
            nxt_cnt = 4'hf;  // Overlong: dropped at next CR
          end
        end
      end
      ST_EXEC: begin
        nxt_cnt = 4'h0;
        nxt_st  = ST_IDLE;
        nxt_msg = MSG_NONE;
        cmd     = {buf_ff[2], buf_ff[3]};
        has_val = (cnt_ff > 4'd4);
        ok = (cnt_ff >= 4'd4) && (cnt_ff <= 4'(BUF_LEN))
             && is_digit(buf_ff[0]) && is_digit(buf_ff[1]);
        for (int i = 4; i < BUF_LEN; i++) begin
          if (4'(i) < cnt_ff) begin
            ok = ok && is_digit(buf_ff[i]);
            v  = 20'(v * 20'd10) + 20'(buf_ff[i] - CH_ZERO);
          end
        end
        if (ok) begin
          ok = ((7'(buf_ff[0] - CH_ZERO) * 7'd10)
                + 7'(buf_ff[1] - CH_ZERO)) == addr_ff;
        end
        case (cmd)
          CMD_KEY: begin
            echo = {15'h0, lvl_ff};
            if (has_val) begin
              echo = v[16:0];
              if (v == 20'h0) begin
                nxt_lvl = LVL_ENQ;
                nxt_msg = MSG_WP;
              end else if (v == 20'h1) begin
                nxt_lvl = LVL_USER;
                nxt_msg = MSG_USER;
              end else if (v[16:0] == CFG_KEY && v[19:17] == 3'h0) begin
                nxt_lvl = LVL_CFG;
                nxt_msg = MSG_CFG;
              end else begin
                err = ERR_RANGE;
              end
            end
          end
          CMD_RATE: begin
            echo = {10'h0, rate_ff};
            if (has_val) begin
              echo = v[16:0];
              if (lvl_ff == LVL_ENQ) begin
                err = ERR_ACCESS;
              end else if (v < 20'(RATE_STD_MIN) || v > 20'(RATE_STD_MAX)) begin
                err = ERR_RANGE;
              end else begin
                nxt_rate    = v[6:0];
                nxt_stored  = v[6:0];
                nxt_pending = 1'b0;
                nxt_nvw     = 1'b1;
              end
            end
          end
          CMD_XRATE: begin
            echo = {10'h0, rate_ff};
            if (has_val) begin
              echo = v[16:0];
              if (lvl_ff == LVL_ENQ) begin
                err = ERR_ACCESS;
              end else if (v < 20'(RATE_EXT_MIN) || v > 20'(RATE_EXT_MAX)) begin
                err = ERR_RANGE;
              end else if (pending_ff && rate_ff == v[6:0]) begin
                nxt_stored  = v[6:0];
                nxt_pending = 1'b0;
                nxt_nvw     = 1'b1;
                nxt_msg     = MSG_SAVED;
              end else begin
                nxt_rate    = v[6:0];
                nxt_pending = 1'b1;
              end
            end
          end
          CMD_ADDR: begin
            echo = {10'h0, addr_ff};
            if (has_val) begin
              echo = v[16:0];
              if (lvl_ff == LVL_ENQ) begin
                err = ERR_ACCESS;
              end else if (v > 20'(ADDR_MAX)) begin
                err = ERR_RANGE;
              end else if (extad_ff) begin
                err = ERR_CONFLICT;  // Pins own the address
              end else begin
                nxt_addr = v[6:0];
                eaddr    = v[6:0];
                nxt_nvw  = 1'b1;
              end
            end
          end
          CMD_QUERY: begin
            data = 1'b1;
          end
          CMD_CYCL: begin
            data       = 1'b1;
            nxt_cyclic = 1'b1;
          end
          default: begin
            ok = 1'b0;  // Unknown commands are not answered
          end
        endcase
        if (!ok) begin
          // A foreign or malformed telegram changes nothing
          nxt_lvl     = lvl_ff;
          nxt_addr    = addr_ff;
          nxt_rate    = rate_ff;
          nxt_stored  = stored_ff;
          nxt_pending = pending_ff;
          nxt_cyclic  = cyclic_ff;
          nxt_nvw     = 1'b0;
          nxt_msg     = MSG_NONE;
        end else begin
          if (err != 17'h0) begin
            cmd     = CMD_ERR;
            echo    = err;
            nxt_msg = MSG_NONE;
          end
          nxt_body[0]  = CH_EXCL;
          nxt_body[1]  = dec_char({10'h0, eaddr}, 1);
          nxt_body[2]  = dec_char({10'h0, eaddr}, 0);
          nxt_body[3]  = cmd[15:8];
          nxt_body[4]  = cmd[7:0];
          for (int i = 0; i < 5; i++) begin
            nxt_body[5 + i] = dec_char(echo, 4 - i);
          end
          nxt_body[10] = CH_CR;
          nxt_bstart   = 5'd0;
          if (data && err == 17'h0) begin
            nxt_body[3] = nxt_body[1];
            nxt_body[4] = nxt_body[2];
            for (int i = 0; i < 5; i++) begin
              nxt_body[5 + i] = CH_ZERO + {4'h0, meas_bcd_in[(4 - i) * 4 +: 4]};
            end
            nxt_bstart = 5'(DATA_POS);
          end
          nxt_idx = (nxt_msg == MSG_NONE) ? nxt_bstart : 5'd0;
          nxt_st  = (nxt_msg == MSG_NONE) ? ST_ECHO : ST_MSG;
        end
      end
      ST_MSG: begin
        if (!txv_ff || tx_ready_in) begin
          if (idx_ff == 5'd16) begin
            nxt_txd = CH_CR;
            nxt_txv = 1'b1;
            nxt_idx = bstart_ff;
            nxt_st  = ST_ECHO;
          end else begin
            c = msg_char(msg_ff, idx_ff);
            if (c != 8'h0) begin
              nxt_txd = c;
              nxt_txv = 1'b1;
            end
            nxt_idx = idx_ff + 5'd1;
          end
        end
      end
      ST_ECHO: begin
        if (!txv_ff || tx_ready_in) begin
          if (idx_ff == 5'(BODY_LEN)) begin
            nxt_st  = ST_IDLE;
            nxt_idx = 5'd0;
          end else begin
            nxt_txd = body_ff[idx_ff[3:0]];
            nxt_txv = 1'b1;
            nxt_idx = idx_ff + 5'd1;
          end
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_ff      <= ST_LOAD;
      buf_ff     <= '0;
      cnt_ff     <= 4'h0;
      lvl_ff     <= LVL_ENQ;
      addr_ff    <= ADDR_DEFAULT;
      rate_ff    <= RATE_DEFAULT;
      stored_ff  <= RATE_DEFAULT;
      pending_ff <= 1'b0;
      cyclic_ff  <= 1'b0;
      extad_ff   <= 1'b0;
      msg_ff     <= MSG_NONE;
      idx_ff     <= 5'd0;
      body_ff    <= '0;
      bstart_ff  <= 5'd0;
      txd_ff     <= 8'h0;
      txv_ff     <= 1'b0;
      nvw_ff     <= 1'b0;
      drive_ff   <= 1'b1;
    end else begin
      st_ff      <= nxt_st;
      buf_ff     <= nxt_buf;
      cnt_ff     <= nxt_cnt;
      lvl_ff     <= nxt_lvl;
      addr_ff    <= nxt_addr;
      rate_ff    <= nxt_rate;
      stored_ff  <= nxt_stored;
      pending_ff <= nxt_pending;
      cyclic_ff  <= nxt_cyclic;
      extad_ff   <= nxt_extad;
      msg_ff     <= nxt_msg;
      idx_ff     <= nxt_idx;
      body_ff    <= nxt_body;
      bstart_ff  <= nxt_bstart;
      txd_ff     <= nxt_txd;
      txv_ff     <= nxt_txv;
      nvw_ff     <= nxt_nvw;
      drive_ff   <= nxt_drive;
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  status_s     stat;
  logic        nxt_half;
  logic [31:0] rdata_ff, nxt_rdata;

  always_comb begin
    stat      = '{level: lvl_ff, pending: pending_ff, cyclic: cyclic_ff,
                  rate: rate_ff, addr: addr_ff};
    nxt_half  = half_ff;
    nxt_rdata = 32'h0;
    if (reg_we_in && reg_addr_in == REG_CTRL) begin
      nxt_half = reg_wdata_in[CTRL_HALF_BIT];
    end
    if (reg_re_in) begin
      if (reg_addr_in == REG_STATUS) begin
        nxt_rdata = {14'h0, stat};
      end else if (reg_addr_in == REG_CTRL) begin
        nxt_rdata = {31'h0, half_ff};
      end else begin
        nxt_rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      half_ff  <= CTRL_HALF_RST;
      rdata_ff <= 32'h0;
    end else begin
      half_ff  <= nxt_half;
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Intake stalls while a telegram is handled, so no byte is lost
  assign rx_ready_out     = (st_ff == ST_IDLE);
  assign tx_data_out      = txd_ff;
  assign tx_valid_out     = txv_ff;
  // Half duplex releases the line between replies for other stations
  assign tx_drive_out     = drive_ff;
  assign nv_rate_out      = stored_ff;
  assign nv_addr_out      = addr_ff;
  assign nv_write_out     = nvw_ff;
  assign rate_code_out    = rate_ff;
  assign baud_div_out     = 14'(CLK_HZ / rate_baud(rate_ff));
  assign access_level_out = lvl_ff;
  assign cyclic_out       = cyclic_ff;
  assign reg_rdata_out    = rdata_ff;

endmodule : cmd_access

`default_nettype wire

// ---- hw/cmd_access_pkg.sv ----
/*
 * Constants, types and encodings for the serial command interpreter.
 * Assumes byte-wide receive and transmit streams from a separate UART.
 */
`default_nettype none
package cmd_access_pkg;

  localparam int unsigned CLK_HZ    = 10000000;
  localparam int unsigned BUF_LEN   = 9;
  localparam int unsigned BODY_LEN  = 11;
  localparam int unsigned DATA_POS  = 3;
  localparam int unsigned LOAD_WAIT = 3;

  // Characters
  localparam logic [7:0] CH_CR   = 8'h0d;
  localparam logic [7:0] CH_EXCL = 8'h21;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;

  // Two-letter commands, first letter in the high byte
  localparam logic [15:0] CMD_KEY   = 16'h4b59;
  localparam logic [15:0] CMD_RATE  = 16'h4252;
  localparam logic [15:0] CMD_XRATE = 16'h4258;
  localparam logic [15:0] CMD_ADDR  = 16'h4944;
  localparam logic [15:0] CMD_QUERY = 16'h5452;
  localparam logic [15:0] CMD_CYCL  = 16'h5454;
  localparam logic [15:0] CMD_ERR   = 16'h4345;

  localparam logic [16:0] ERR_ACCESS   = 17'h00008;
  localparam logic [16:0] ERR_RANGE    = 17'h00010;
  localparam logic [16:0] ERR_CONFLICT = 17'h00020;

  // Rate codes and address settings
  localparam logic [6:0] RATE_STD_MIN = 7'h02;
  localparam logic [6:0] RATE_STD_MAX = 7'h09;
  localparam logic [6:0] RATE_EXT_MIN = 7'h65;
  localparam logic [6:0] RATE_EXT_MAX = 7'h67;
  localparam logic [6:0] RATE_DEFAULT = 7'h05;
  localparam logic [6:0] ADDR_DEFAULT = 7'h00;
  localparam logic [6:0] ADDR_MAX     = 7'h63;

  // Register indices on the plain port
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL   = 4'h1;
  localparam int unsigned CTRL_HALF_BIT = 0;
  localparam logic        CTRL_HALF_RST = 1'b0;

  typedef enum logic [1:0] {
    LVL_ENQ  = 2'b00,
    LVL_USER = 2'b01,
    LVL_CFG  = 2'b10
  } level_e;

  typedef enum logic [2:0] {
    MSG_NONE  = 3'b000,
    MSG_WP    = 3'b001,
    MSG_USER  = 3'b010,
    MSG_CFG   = 3'b011,
    MSG_SAVED = 3'b100
  } msg_e;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_MSG  = 3'b011,
    ST_ECHO = 3'b100
  } state_e;

  typedef struct packed {
    level_e     level;
    logic       pending;
    logic       cyclic;
    logic [6:0] rate;
    logic [6:0] addr;
  } status_s;

  typedef logic [BUF_LEN-1:0][7:0]  rxbuf_t;
  typedef logic [BODY_LEN-1:0][7:0] body_t;

endpackage : cmd_access_pkg

`default_nettype wire

// ---- tb/cmd_access_asserts.sv ----
/*
 * Port checker for the command interpreter.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module cmd_access_asserts
  import cmd_access_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic [7:0]  rx_data_in,
  input wire logic        rx_valid_in,
  input wire logic        rx_ready_out,
  input wire logic [7:0]  tx_data_out,
  input wire logic        tx_valid_out,
  input wire logic        tx_ready_in,
  input wire logic        tx_drive_out,
  input wire logic [6:0]  nv_addr_out,
  input wire logic        nv_write_out,
  input wire logic [6:0]  rate_code_out,
  input wire logic [1:0]  access_level_out,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_we_in,
  input wire logic        reg_re_in,
  input wire logic [31:0] reg_rdata_out
);
  // ****
  // Shadow of the duplex bit
  // ****
  logic half_ff;
  logic nxt_half;

  always_comb begin
    nxt_half = half_ff;
    if (!rst_b_in) begin
      nxt_half = 1'b0;
    end else if (reg_we_in && reg_addr_in == REG_CTRL) begin
      nxt_half = reg_wdata_in[CTRL_HALF_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    half_ff <= nxt_half;
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  AST_RST_STATE:
  assert property (!$past(rst_b_in) |-> access_level_out == LVL_ENQ && tx_drive_out
    && !tx_valid_out && rate_code_out == RATE_DEFAULT) else $error("bad reset state");
  AST_CR_FLUSH:
  assert property (rx_valid_in && rx_ready_out && rx_data_in == CH_CR |=> !rx_ready_out)
    else $error("receive not stopped after CR");
  AST_TX_HOLD:
  assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("reply byte dropped");
  AST_RATE_SET:
  assert property (rate_code_out inside {[RATE_STD_MIN:RATE_STD_MAX],
    [RATE_EXT_MIN:RATE_EXT_MAX]}) else $error("rate code out of range");
  AST_EXT_NOSAVE:
  assert property ($changed(rate_code_out) && rate_code_out >= RATE_EXT_MIN |-> !nv_write_out)
    else $error("extended rate stored at once");
  AST_NV_PULSE:
  assert property (nv_write_out |=> !nv_write_out) else $error("store pulse too long");
  AST_ADDR_MAX:
  assert property (nv_write_out |-> nv_addr_out <= ADDR_MAX) else $error("address above 99");
  AST_FULL_DRIVE:
  assert property ((!half_ff)[*3] |-> tx_drive_out) else $error("driver off in full duplex");
  AST_LVL_READ:
  assert property (reg_re_in && reg_addr_in == REG_STATUS |=>
    reg_rdata_out[17:16] == $past(access_level_out)) else $error("status level mismatch");

  COV_CR: cover property (rx_valid_in && rx_ready_out && rx_data_in == CH_CR);
  COV_SAVE: cover property (nv_write_out);
  COV_CFG: cover property (access_level_out == LVL_CFG);
endmodule : cmd_access_asserts

bind cmd_access cmd_access_asserts i_chk (.*);
`default_nettype wire

// ---- tb/host_model.sv ----
/*
 * Behavioural host that stands on the far side of the byte streams.
 * Assumes the bench calls put() just after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk_in,
  input  wire logic       rx_ready_in,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out
);
  // ****
  // Reply capture, right-justified, with optional stalling
  // ****
  logic [255:0] rep   = '0;
  int           cnt   = 0;
  logic         slow  = 1'b0;

  initial begin
    rx_data_out  = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b1;
  end

  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      rep <= {rep[247:0], tx_data_in};
      cnt <= cnt + 1;
    end
    tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
  end

  // Single master: one telegram at a time, byte held until taken
  task automatic put(input string s);
    foreach (s[i]) begin
      rx_data_out  <= s[i];
      rx_valid_out <= 1'b1;
      do @(posedge clk_in); while (rx_ready_in !== 1'b1);
    end
    // Released stream shows garbage, so only valid may qualify a byte
    rx_data_out  <= ~rx_data_out;
    rx_valid_out <= 1'b0;
  endtask : put
endmodule : host_model
`default_nettype wire

// ---- tb/serial_command_access_control_tb.sv ----
/*
 * Self-checking bench for the command interpreter.
 * Assumes host_model on the byte streams and the checker bound in.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_command_access_control_tb;
  import cmd_access_pkg::*;
  // ****
  // Signals and instances
  // ****
  logic        clk_in, rst_b_in, rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in;
  logic        tx_drive_out, nv_valid_in, nv_ext_addr_in, nv_write_out, cyclic_out;
  logic        reg_we_in, reg_re_in;
  logic [7:0]  rx_data_in, tx_data_out;
  logic [19:0] meas_bcd_in;
  logic [2:0]  ext_addr_pins_in;
  logic [6:0]  nv_rate_in, nv_addr_in, nv_rate_out, nv_addr_out, rate_code_out;
  logic [13:0] baud_div_out;
  logic [1:0]  access_level_out;
  logic [3:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  int          num_errors = 0;
  int          compares   = 0;
  int          nv_n       = 0;

  cmd_access i_dut (.*);
  host_model i_host (.clk_in(clk_in), .rx_ready_in(rx_ready_out), .rx_data_out(rx_data_in),
    .rx_valid_out(rx_valid_in), .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out),
    .tx_ready_out(tx_ready_in));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (nv_write_out === 1'b1) nv_n <= nv_n + 1;
  end

  // ****
  // Tasks
  // ****
  task automatic check(input string w, input logic [255:0] s, e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", w, e, s);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_we_in    <= 1'b1;
    @(posedge clk_in);
    reg_we_in    <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    reg_addr_in <= a;
    reg_re_in   <= 1'b1;
    @(posedge clk_in);
    reg_re_in   <= 1'b0;
    @(posedge clk_in);
    check("reg", reg_rdata_out, e);
  endtask : rchk

  // Leading CR flushes stray bytes; n = expected reply length
  task automatic cmd(input string s, input int n, input logic [255:0] e);
    int c0;
    int k;
    c0 = i_host.cnt;
    i_host.put({"\015", s, "\015"});
    for (k = 0; k < 300 && (n == 0 || i_host.cnt < c0 + n); k++) @(posedge clk_in);
    check(s, i_host.cnt - c0, n);
    check(s, i_host.rep & ((256'h1 << (8 * n)) - 256'h1), e);
  endtask : cmd

  task automatic restart(input logic v, x);
    int k;
    nv_valid_in    <= v;
    nv_ext_addr_in <= x;
    rst_b_in       <= 1'b0;
    repeat (5) @(posedge clk_in);
    rst_b_in       <= 1'b1;
    for (k = 0; k < 50 && rx_ready_out !== 1'b1; k++) @(posedge clk_in);
  endtask : restart

  task automatic stop_test;
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    stop_test();
  end

  // ****
  // Sequence
  // ****
  initial begin
    {reg_we_in, reg_re_in, reg_addr_in, reg_wdata_in} <= '0;
    meas_bcd_in      <= 20'h12345;
    ext_addr_pins_in <= 3'h5;
    nv_rate_in       <= 7'h07;
    nv_addr_in       <= 7'h09;
    restart(1'b0, 1'b0);
    rchk(REG_STATUS, 32'h00000280);
    rchk(4'h7, 32'h0);
    wr(REG_CTRL, 32'h1);
    rchk(REG_CTRL, 32'h1);
    check("drive", tx_drive_out, 1'b0);
    wr(REG_CTRL, 32'h0);
    cmd("00BR00006", 11, "!00CE00008\015");
    cmd("00KY00001", 23, "USER ACCESS\015!00KY00001\015");
    cmd("00BR00010", 11, "!00CE00016\015");
    cmd("00BR00001", 11, "!00CE00016\015");
    cmd("00BR00009", 11, "!00BR00009\015");
    check("rate", rate_code_out, 7'h09);
    check("baud", baud_div_out, 14'd86);
    check("store", nv_n, 1);
    cmd("00BX00101", 11, "!00BX00101\015");
    check("rate", rate_code_out, 7'h65);
    check("baud", baud_div_out, 14'd43);
    check("store", nv_n, 1);
    i_host.slow <= 1'b1;
    cmd("00BX00101", 27, "BAUD RATE SAVED\015!00BX00101\015");
    i_host.slow <= 1'b0;
    check("store", nv_n, 2);
    check("nvrate", nv_rate_out, 7'h65);
    cmd("00ID00004", 11, "!04ID00004\015");
    check("nvaddr", nv_addr_out, 7'h04);
    cmd("00KY00000", 0, 0);
    i_host.put("04K");
    @(posedge clk_in);
    cmd("04KY", 11, "!04KY00001\015");
    cmd("04TR", 8, "0412345\015");
    cmd("04TT", 8, "0412345\015");
    check("cyclic", cyclic_out, 1'b1);
    cmd("04ID00100", 11, "!04CE00016\015");
    cmd("04KY12345", 25, "CONFIG ACCESS\015!04KY12345\015");
    check("level", access_level_out, LVL_CFG);
    cmd("04KY00007", 11, "!04CE00016\015");
    cmd("04KY00000", 27, "WRITE PROTECTED\015!04KY00000\015");
    cmd("04ID00005", 11, "!04CE00008\015");
    restart(1'b1, 1'b1);
    rchk(REG_STATUS, 32'h00000385);
    cmd("05KY00001", 23, "USER ACCESS\015!05KY00001\015");
    cmd("05ID00009", 11, "!05CE00032\015");
    restart(1'b1, 1'b0);
    rchk(REG_STATUS, 32'h00000389);
    stop_test();
  end
endmodule : serial_command_access_control_tb
`default_nettype wire
